// file: core/isb_pkg.sv
// Shared constants and types for the interpolation set-point buffer.
package isb_pkg;

   // Clock rate and the period base for each supported time index.
   localparam int CLK_HZ      = 20_000_000;
   localparam int BASE_E6     = CLK_HZ / 1_000_000;
   localparam int BASE_E5     = CLK_HZ / 100_000;
   localparam int BASE_E4     = CLK_HZ / 10_000;
   localparam int BASE_E3     = CLK_HZ / 1_000;
   localparam int BASE_E2     = CLK_HZ / 100;
   localparam int BASE_W      = 18;
   localparam int PERIOD_W    = 26;

   // Configuration entry numbers.
   localparam logic [2:0] SUB_COUNT = 3'h0;
   localparam logic [2:0] SUB_MAX   = 3'h1;
   localparam logic [2:0] SUB_SIZE  = 3'h2;
   localparam logic [2:0] SUB_ORG   = 3'h3;
   localparam logic [2:0] SUB_SLOT  = 3'h4;
   localparam logic [2:0] SUB_BYTES = 3'h5;
   localparam logic [2:0] SUB_CLEAR = 3'h6;

   // Entry values and reset values.
   localparam logic [7:0] NUM_ENTRIES   = 8'h06;
   localparam logic [4:0] MAX_PV        = 5'h10;
   localparam logic [4:0] MAX_POS       = 5'h01;
   localparam logic [4:0] SIZE_RESET    = 5'h01;
   localparam logic [7:0] BYTES_PV      = 8'h08;
   localparam logic [7:0] BYTES_POS     = 8'h04;
   localparam logic [7:0] ORG_FIFO      = 8'h00;
   localparam logic [7:0] ORG_RING      = 8'h01;
   localparam logic [7:0] CLR_FLUSH     = 8'h00;
   localparam logic [7:0] CLR_OPEN      = 8'h01;
   localparam logic [7:0] ERR_ACTIVE    = 8'hB9;
   localparam logic [7:0] ERR_ACCESS    = 8'h01;

   // One interpolation data record: target velocity over target position.
   typedef struct packed {
      logic [31:0] vel;
      logic [31:0] pos;
   } isb_rec_t;

   // One configuration access from the host controller.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [2:0]  sub;
      logic [31:0] wdata;
   } isb_cfg_req_t;

   // Interpolation phase.
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_WAIT = 3'b010,
      PH_RUN  = 3'b100
   } isb_phase_t;

endpackage

// file: core/isb_buffer.sv
// Set-point buffer: ingress FIFO, record slots, timebase and events.
`timescale 1ns/1ns

// What this block does
// R1 - Configuration writes while interpolating are refused with abort code 185.
// R2 - Maximum capacity reads 1 record in sub-mode 0, 16 in sub-mode -1.
// R3 - Actual size is writable, legal from one to maximum, resets to one.
// R4 - Organisation 0 is FIFO, 1 is ring, others refused; default FIFO.
// R5 - Record size reads 8 bytes in sub-mode -1, 4 in sub-mode 0.
// R6 - Clear 0 empties buffer and blocks access; clear 1 opens it.
// R7 - Slots are reached only through interpolation data record writes.
// R8 - FIFO appends at tail, interpolator takes head; pointer advances per record.
// R9 - FIFO ignores the position entry and wraps at the actual size.
// R10 - Ring stores each record at the host position; same position overwrites.
// R11 - Ring reads use an internal pointer that clear returns to slot zero.
// R12 - Host sends one record per period in sub-mode 0 or size one.
// R13 - Host keeps the buffer from running empty during interpolation.
// R14 - Missing set-point starts linear extrapolation; fresh data resumes normally.
// R15 - Timeout raises unmasked underflow, halts, clears active bit; mode stays.
// R16 - Underflow detection is armed only after the first set-point.
// R17 - Overwriting an unused record while active raises unmasked overflow; motion continues.
// R18 - No overflow detection in ring organisation.
// R19 - Host avoids overwriting records not yet consumed.
// R20 - Interpolation enable takes effect at the next SYNC, which is time zero.
// R21 - Internal timebase aligns to SYNC arrivals and the configured period.
// R22 - Sub-mode -1 records hold position and velocity; sub-mode 0 position only.
// R23 - Period equals time unit times ten to the time index seconds; the code supports indices -6 to -2 and treats any other index as -3.
// R24 - A count of unconsumed records detects empty and overwrite conditions.

// Ingress FIFO between the record port and the slot store.
module isb_fifo #(
   parameter int W     = 64,
   parameter int DEPTH = 32
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } isb_fifo_st_t;

   isb_fifo_st_t s_q;
   isb_fifo_st_t s_d;
   logic         push;
   logic         pop;

   // Depth must be a power of two so the pointers wrap by themselves.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("isb_fifo depth must be a power of two");
   end

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next state; a flush drops everything, including a push in that cycle.
   always_comb begin
      s_d = s_q;
      if (flush) begin
         s_d.wp  = '0;
         s_d.rp  = '0;
         s_d.cnt = '0;
      end else begin
         if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp          = s_q.wp + 1'b1;
         end
         if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
         end
         s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// Top: configuration entries, record slots, period timebase and events.
module isb_buffer #(
   parameter int SLOTS      = 16,
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic                  REF_CLK,
   input  wire logic                  RESET_N,
   input  wire isb_pkg::isb_cfg_req_t CFG_REQ,
   output logic                       CFG_ACK,
   output logic                       CFG_ABORT,
   output logic [7:0]                 CFG_ERR,
   output logic [31:0]                CFG_RDATA,
   input  wire logic                  REC_VALID,
   output logic                       REC_READY,
   input  wire isb_pkg::isb_rec_t     REC_DATA,
   input  wire logic                  SUBMODE_PV,
   input  wire logic                  IP_ENABLE,
   input  wire logic [7:0]            TIME_UNIT,
   input  wire logic signed [7:0]     TIME_INDEX,
   input  wire logic [7:0]            TIMEOUT_PERIODS,
   input  wire logic                  UF_MASK,
   input  wire logic                  OF_MASK,
   input  wire logic                  SYNC,
   output logic                       SP_VALID,
   output isb_pkg::isb_rec_t          SP_DATA,
   output logic                       SP_EXTRAP,
   output logic                       INTERP_ACTIVE,
   output logic                       HALT_REQ,
   output logic                       EMCY_UNDERFLOW,
   output logic                       EMCY_OVERFLOW,
   output logic [4:0]                 BUF_LEVEL
);
   if (SLOTS != 16 || FIFO_DEPTH < 2) begin : g_chk
      $error("isb_buffer supports 16 slots and a FIFO of two or more");
   end

   typedef struct packed {
      isb_pkg::isb_rec_t [SLOTS-1:0] slots;
      isb_pkg::isb_phase_t           ph;
      logic [4:0]                    size;
      logic                          ring;
      logic [3:0]                    wslot;
      logic                          open;
      logic [3:0]                    wr;
      logic [3:0]                    rd;
      logic [4:0]                    count;
      logic                          armed;
      logic [7:0]                    miss;
      logic [31:0]                   step;
      logic [isb_pkg::PERIOD_W-1:0]  tick;
      logic                          sync1;
      logic                          sync2;
      logic                          sync3;
      logic                          en;
      logic                          ack;
      logic                          abort;
      logic [7:0]                    err;
      logic [31:0]                   rdata;
      logic                          spv;
      isb_pkg::isb_rec_t             sp;
      logic                          extrap;
      logic                          halt;
      logic                          uf;
      logic                          of;
   } isb_st_t;

   isb_st_t                      s_q;
   isb_st_t                      s_d;
   logic                         flush;
   logic                         st_valid;
   logic                         st_ready;
   isb_pkg::isb_rec_t            st_data;
   logic [4:0]                   max_cap;
   logic [4:0]                   size_eff;
   logic                         sync_rise;
   logic [isb_pkg::PERIOD_W-1:0] period;
   logic                         boundary;
   logic                         run_now;
   logic                         store;
   logic                         pop;
   logic                         ovf;
   logic [3:0]                   st_slot;

   // Cycles per time unit for a time index; unsupported indices act as -3.
   function automatic logic [isb_pkg::BASE_W-1:0] base_cycles(
      input logic signed [7:0] idx);
      case (idx)
         -8'sd6:  base_cycles = isb_pkg::BASE_W'(isb_pkg::BASE_E6);
         -8'sd5:  base_cycles = isb_pkg::BASE_W'(isb_pkg::BASE_E5);
         -8'sd4:  base_cycles = isb_pkg::BASE_W'(isb_pkg::BASE_E4);
         -8'sd2:  base_cycles = isb_pkg::BASE_W'(isb_pkg::BASE_E2);
         default: base_cycles = isb_pkg::BASE_W'(isb_pkg::BASE_E3);
      endcase
   endfunction

   // Advance a slot pointer, wrapping at the actual buffer size.
   function automatic logic [3:0] next_ptr(input logic [3:0] p,
                                          input logic [4:0] sz);
      next_ptr = ({1'b0, p} + 5'h01 >= sz) ? 4'h0 : p + 4'h1;
   endfunction

   // Records queue here until the slot store can take them; while the
   // buffer is closed, or full outside interpolation in FIFO layout, they back up until the full FIFO stalls the host.
   isb_fifo #(
      .W     ($bits(isb_pkg::isb_rec_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (REF_CLK),
      .rst_n     (RESET_N),
      .flush     (flush),
      .in_valid  (REC_VALID),
      .in_ready  (REC_READY),
      .in_data   (REC_DATA),
      .out_valid (st_valid),
      .out_ready (st_ready),
      .out_data  (st_data)
   );

   // Capacity follows the sub-mode; a stale larger size is clipped.
   assign max_cap  = SUBMODE_PV ? isb_pkg::MAX_PV : isb_pkg::MAX_POS; // see R2
   assign size_eff = (s_q.size > max_cap) ? max_cap : s_q.size;

   // Period in clock cycles; a zero unit is read as one.
   assign period = ({18'h0, (TIME_UNIT == 8'h00) ? 8'h01 : TIME_UNIT}
                   * {8'h0, base_cycles(TIME_INDEX)}); // see R23

   // Each SYNC arrival restarts the period count; see R21.
   assign sync_rise = s_q.sync2 && !s_q.sync3;
   assign boundary  = sync_rise || (s_q.tick >= period - 1'b1);
   assign run_now   = (s_q.ph == isb_pkg::PH_RUN) ||
                      ((s_q.ph == isb_pkg::PH_WAIT) && sync_rise); // see R20

   // Clear 0 written outside interpolation discards queued records too.
   assign flush = CFG_REQ.wr && (CFG_REQ.sub == isb_pkg::SUB_CLEAR) &&
                  (s_q.ph != isb_pkg::PH_RUN) &&
                  (CFG_REQ.wdata[7:0] == isb_pkg::CLR_FLUSH); // see R6

   // Store path: only the record port reaches the slots; see R7.
   assign st_ready = s_q.open && !flush &&
                     (s_q.ring || s_q.ph == isb_pkg::PH_RUN ||
                      s_q.count < size_eff);
   assign store    = st_valid && st_ready;
   assign pop      = run_now && boundary && (s_q.count != 5'h00);
   assign st_slot  = s_q.ring ? s_q.wslot : s_q.wr; // see R9 R10
   // A full FIFO store while running drops the oldest unused record.
   assign ovf      = store && !pop && !s_q.ring &&
                     s_q.ph == isb_pkg::PH_RUN &&
                     s_q.count >= size_eff; // see R17 R18 R19

   // All next-state logic.
   always_comb begin
      s_d        = s_q;
      s_d.ack    = 1'b0;
      s_d.abort  = 1'b0;
      s_d.err    = 8'h00;
      s_d.spv    = 1'b0;
      s_d.halt   = 1'b0;
      s_d.uf     = 1'b0;
      s_d.of     = 1'b0;
      s_d.sync1  = SYNC;
      s_d.sync2  = s_q.sync1;
      s_d.sync3  = s_q.sync2;
      s_d.en     = IP_ENABLE;
      s_d.tick   = boundary ? '0 : s_q.tick + 1'b1;

      // Configuration accesses answer one cycle later.
      if (CFG_REQ.rd) begin
         s_d.ack   = 1'b1;
         s_d.rdata = 32'h0000_0000;
         case (CFG_REQ.sub)
            isb_pkg::SUB_COUNT: s_d.rdata[7:0] = isb_pkg::NUM_ENTRIES;
            isb_pkg::SUB_MAX:   s_d.rdata[4:0] = max_cap; // see R2
            isb_pkg::SUB_SIZE:  s_d.rdata[4:0] = size_eff;
            isb_pkg::SUB_ORG:   s_d.rdata[0]   = s_q.ring;
            isb_pkg::SUB_SLOT:  s_d.rdata[3:0] = s_q.wslot;
            isb_pkg::SUB_BYTES: s_d.rdata[7:0] = SUBMODE_PV ?
               isb_pkg::BYTES_PV : isb_pkg::BYTES_POS; // see R5
            default: begin
               s_d.abort = 1'b1;
               s_d.err   = isb_pkg::ERR_ACCESS;
            end
         endcase
      end else if (CFG_REQ.wr) begin
         s_d.ack = 1'b1;
         if (s_q.ph == isb_pkg::PH_RUN) begin
            s_d.abort = 1'b1;
            s_d.err   = isb_pkg::ERR_ACTIVE; // see R1
         end else begin
            s_d.abort = 1'b1;
            s_d.err   = isb_pkg::ERR_ACCESS;
            case (CFG_REQ.sub)
               isb_pkg::SUB_SIZE: begin
                  if (CFG_REQ.wdata != 32'h0 &&
                      CFG_REQ.wdata <= {27'h0, max_cap}) begin
                     s_d.size  = CFG_REQ.wdata[4:0]; // see R3
                     s_d.abort = 1'b0;
                  end
               end
               isb_pkg::SUB_ORG: begin
                  if (CFG_REQ.wdata[31:1] == 31'h0) begin
                     s_d.ring  = CFG_REQ.wdata[0]; // see R4
                     s_d.abort = 1'b0;
                  end
               end
               isb_pkg::SUB_SLOT: begin
                  if (CFG_REQ.wdata[31:4] == 28'h0) begin
                     s_d.wslot = CFG_REQ.wdata[3:0];
                     s_d.abort = 1'b0;
                  end
               end
               isb_pkg::SUB_CLEAR: begin
                  if (CFG_REQ.wdata[7:0] == isb_pkg::CLR_FLUSH) begin
                     s_d.open  = 1'b0;
                     s_d.abort = 1'b0;
                  end else if (CFG_REQ.wdata[7:0] == isb_pkg::CLR_OPEN) begin
                     s_d.open  = 1'b1; // see R6
                     s_d.abort = 1'b0;
                  end
               end
               default: ;
            endcase
            if (s_d.abort == 1'b0) begin
               s_d.err = 8'h00;
            end
         end
      end

      // Slot store; sub-mode 0 keeps position only.
      if (store) begin
         s_d.slots[st_slot].pos = st_data.pos;
         s_d.slots[st_slot].vel = SUBMODE_PV ? st_data.vel : 32'h0; // see R22
         s_d.armed              = 1'b1; // see R16
         if (!s_q.ring) begin
            s_d.wr = next_ptr(s_q.wr, size_eff); // see R8 R9
         end
      end

      // Pop at a period boundary; the read pointer serves both layouts.
      if (pop) begin
         s_d.rd     = next_ptr(s_q.rd, size_eff); // see R8 R11
         s_d.spv    = 1'b1;
         s_d.sp     = s_q.slots[s_q.rd];
         s_d.step   = s_q.slots[s_q.rd].pos - s_q.sp.pos;
         s_d.extrap = 1'b0;
         s_d.miss   = 8'h00; // see R14
      end else if (run_now && boundary && s_q.armed) begin
         // No fresh set-point: extrapolate until the timeout runs out.
         if (s_q.miss >= TIMEOUT_PERIODS) begin
            s_d.uf     = !UF_MASK; // see R15
            s_d.halt   = 1'b1;
            s_d.extrap = 1'b0;
            s_d.ph     = isb_pkg::PH_IDLE;
         end else begin
            s_d.spv    = 1'b1;
            s_d.extrap = 1'b1; // see R14
            s_d.sp.pos = s_q.sp.pos + s_q.step;
            s_d.miss   = s_q.miss + 8'h01;
         end
      end

      // Unconsumed count; a ring saturates since slots are host-chosen.
      if (ovf) begin
         s_d.rd = next_ptr(s_q.rd, size_eff);
         s_d.of = !OF_MASK; // see R17
      end else if (store && !pop) begin
         s_d.count = (s_q.count >= size_eff) ? size_eff
                                             : s_q.count + 5'h01; // see R24
      end else if (pop && !store) begin
         s_d.count = s_q.count - 5'h01;
      end

      // Phase control; an enable edge waits for SYNC.
      unique case (s_q.ph)
         isb_pkg::PH_IDLE: begin
            if (IP_ENABLE && !s_q.en) begin
               s_d.ph = isb_pkg::PH_WAIT;
            end
         end
         isb_pkg::PH_WAIT: begin
            if (!IP_ENABLE) begin
               s_d.ph = isb_pkg::PH_IDLE;
            end else if (sync_rise && s_d.ph == isb_pkg::PH_WAIT) begin
               s_d.ph = isb_pkg::PH_RUN; // see R20
            end
         end
         isb_pkg::PH_RUN: begin
            if (!IP_ENABLE) begin
               s_d.ph = isb_pkg::PH_IDLE;
            end
         end
         default: s_d.ph = isb_pkg::PH_IDLE;
      endcase
      if (s_d.ph == isb_pkg::PH_IDLE) begin
         s_d.miss = 8'h00;
      end

      // Clear zero returns the read and write pointers to the first slot; the ring slot position keeps its value.
      if (flush) begin
         s_d.count = 5'h00;
         s_d.wr    = 4'h0;
         s_d.rd    = 4'h0; // see R11
         s_d.armed = 1'b0;
      end
   end

   // State register; reset gives FIFO layout, size one, buffer closed.
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q      <= '0;
         s_q.ph   <= isb_pkg::PH_IDLE;
         s_q.size <= isb_pkg::SIZE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops; INTERP_ACTIVE is decoded from the phase.
   assign CFG_ACK        = s_q.ack;
   assign CFG_ABORT      = s_q.abort;
   assign CFG_ERR        = s_q.err;
   assign CFG_RDATA      = s_q.rdata;
   assign SP_VALID       = s_q.spv;
   assign SP_DATA        = s_q.sp;
   assign SP_EXTRAP      = s_q.extrap;
   assign INTERP_ACTIVE  = (s_q.ph == isb_pkg::PH_RUN);
   assign HALT_REQ       = s_q.halt;
   assign EMCY_UNDERFLOW = s_q.uf;
   assign EMCY_OVERFLOW  = s_q.of;
   assign BUF_LEVEL      = s_q.count;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   cfg_lock_a: assert property ( // see R1
      CFG_REQ.wr && !CFG_REQ.rd && INTERP_ACTIVE |=>
         CFG_ACK && CFG_ABORT && CFG_ERR == isb_pkg::ERR_ACTIVE)
      else $error("write while active not refused with 185");
   max_cap_a: assert property ( // see R2
      CFG_REQ.rd && CFG_REQ.sub == isb_pkg::SUB_MAX |=>
         CFG_RDATA == ($past(SUBMODE_PV) ? 32'h10 : 32'h1))
      else $error("wrong maximum capacity");
   size_range_a: assert property ( // see R3
      s_q.size != 5'h00 && s_q.size <= isb_pkg::MAX_PV)
      else $error("actual size out of range");
   org_keep_a: assert property ( // see R4
      CFG_REQ.wr && !CFG_REQ.rd && CFG_REQ.sub == isb_pkg::SUB_ORG &&
      CFG_REQ.wdata > 32'h1 |=> $stable(s_q.ring) && CFG_ABORT)
      else $error("reserved organisation accepted");
   rec_bytes_a: assert property ( // see R5
      CFG_REQ.rd && CFG_REQ.sub == isb_pkg::SUB_BYTES |=>
         CFG_RDATA == ($past(SUBMODE_PV) ? 32'h8 : 32'h4))
      else $error("wrong record size");
   flush_a: assert property ( // see R6
      flush |=> BUF_LEVEL == 5'h00 && !s_q.open && s_q.rd == 4'h0
                ##1 !st_ready)
      else $error("clear did not empty and block buffer");
   ring_slot_a: assert property ( // see R10
      store && s_q.ring |=>
         s_q.slots[$past(s_q.wslot)].pos == $past(st_data.pos))
      else $error("ring record not at host position");
   underflow_a: assert property ( // see R15
      EMCY_UNDERFLOW |-> HALT_REQ && !INTERP_ACTIVE && s_q.armed == 1'b1)
      else $error("underflow without halt or arming");
   ring_no_ovf_a: assert property ( // see R18
      s_q.ring |=> !EMCY_OVERFLOW)
      else $error("overflow raised in ring layout");
   sync_start_a: assert property ( // see R20
      $rose(INTERP_ACTIVE) |-> $past(sync_rise))
      else $error("interpolation started off SYNC");

   run_cov_c: cover property (pop ##[1:200] EMCY_UNDERFLOW);
   extrap_cov_c: cover property (SP_EXTRAP ##[1:200] (SP_VALID && !SP_EXTRAP));
   ovf_cov_c: cover property (EMCY_OVERFLOW);
endmodule

// file: sim/isb_host_model.sv
// Host-side source of interpolation data records.
`timescale 1ns/1ns

module isb_host_model (
   input  wire logic         clk,
   input  wire logic         go,
   input  wire logic         gap,
   input  wire logic [5:0]   count,
   input  wire logic [31:0]  base,
   input  wire logic         rdy,
   output logic              vld,
   output isb_pkg::isb_rec_t dat,
   output logic              busy
);
   int   i;
   logic t;

   initial begin
      vld = 1'b0;
      dat = '0;
      busy = 1'b0;
   end

   // Records go out in order, one per beat, held until taken.
   // A slow host leaves a gap, and released data is scrambled, not held.
   always begin
      @(posedge clk);
      if (go) begin
         busy <= 1'b1;
         for (i = 0; i < count; i++) begin
            vld <= 1'b1;
            dat <= '{vel: 32'(i), pos: base + 32'(i)};
            do begin
               @(negedge clk);
               t = rdy;
               @(posedge clk);
            end while (!t);
            if (gap) begin
               vld <= 1'b0;
               dat <= ~dat;
               @(posedge clk);
            end
         end
         vld <= 1'b0;
         dat <= ~dat;
         busy <= 1'b0;
      end
   end
endmodule

// file: sim/isb_buffer_tb_top.sv
// Self-checking bench for the set-point buffer.
`timescale 1ns/1ns

module isb_buffer_tb_top;
   logic                  REF_CLK, RESET_N, CFG_ACK, CFG_ABORT;
   logic                  REC_VALID, REC_READY, SUBMODE_PV, IP_ENABLE;
   logic                  SYNC, SP_VALID, SP_EXTRAP, INTERP_ACTIVE;
   logic                  HALT_REQ, EMCY_UNDERFLOW, EMCY_OVERFLOW;
   logic                  UF_MASK, OF_MASK, go, gap, busy;
   logic [7:0]            CFG_ERR, TIME_UNIT, TIMEOUT_PERIODS;
   logic signed [7:0]     TIME_INDEX;
   logic [31:0]           CFG_RDATA;
   logic [4:0]            BUF_LEVEL;
   logic [5:0]            cnt;
   isb_pkg::isb_cfg_req_t CFG_REQ;
   isb_pkg::isb_rec_t     REC_DATA, SP_DATA;
   int                    err_count, checked;

   isb_buffer uut (.REF_CLK, .RESET_N, .CFG_REQ, .CFG_ACK, .CFG_ABORT,
      .CFG_ERR, .CFG_RDATA, .REC_VALID, .REC_READY, .REC_DATA,
      .SUBMODE_PV, .IP_ENABLE, .TIME_UNIT, .TIME_INDEX, .TIMEOUT_PERIODS,
      .UF_MASK, .OF_MASK, .SYNC, .SP_VALID, .SP_DATA, .SP_EXTRAP,
      .INTERP_ACTIVE, .HALT_REQ, .EMCY_UNDERFLOW, .EMCY_OVERFLOW,
      .BUF_LEVEL);

   isb_host_model host (.clk(REF_CLK), .go(go), .gap(gap), .count(cnt),
      .base(32'h64), .rdy(REC_READY), .vld(REC_VALID), .dat(REC_DATA),
      .busy(busy));

   // Free-running 20 MHz clock.
   initial begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end

   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One access; a refusal is expected whenever an error code is given.
   task automatic cfg(input logic w, input logic [2:0] s,
                      input logic [31:0] wd, input logic [7:0] e,
                      input logic [31:0] rd);
      @(posedge REF_CLK) CFG_REQ <= '{wr: w, rd: !w, sub: s, wdata: wd};
      @(posedge REF_CLK) CFG_REQ <= '0;
      #1 chk(CFG_ACK, 32'h1);
      chk(CFG_ABORT, 32'(e != 8'h00));
      chk(CFG_ERR, 32'(e));
      if (!w && e == 8'h00) chk(CFG_RDATA, rd);
   endtask

   task automatic send(input logic [5:0] n, input logic g);
      int i;
      @(posedge REF_CLK) begin
         cnt <= n;
         gap <= g;
         go <= 1'b1;
      end
      @(posedge REF_CLK) go <= 1'b0;
      for (i = 0; i < 900 && (busy || go); i++) @(posedge REF_CLK) #1;
      chk(busy, 32'h0);
   endtask

   task automatic wait_sp(input logic [31:0] pos);
      int i;
      i = 0;
      do @(posedge REF_CLK) #1; while (SP_VALID !== 1'b1 && ++i < 100);
      chk(SP_VALID, 32'h1);
      chk(SP_DATA.pos, pos);
   endtask

   // Enable, then one SYNC pulse starts the path with the first record.
   task automatic start(input logic [31:0] pos);
      @(posedge REF_CLK) IP_ENABLE <= 1'b1;
      @(posedge REF_CLK) SYNC <= 1'b1;
      wait_sp(pos);
      @(posedge REF_CLK) SYNC <= 1'b0;
   endtask

   task automatic t_regs;
      cfg(1'b0, isb_pkg::SUB_COUNT, 0, 8'h00, 32'h6);
      cfg(1'b0, isb_pkg::SUB_MAX, 0, 8'h00, 32'h1);
      cfg(1'b0, isb_pkg::SUB_BYTES, 0, 8'h00, 32'h4);
      cfg(1'b0, isb_pkg::SUB_SIZE, 0, 8'h00, 32'h1);
      cfg(1'b0, isb_pkg::SUB_ORG, 0, 8'h00, 32'h0);
      cfg(1'b1, isb_pkg::SUB_MAX, 5, 8'h01, 0);
      cfg(1'b0, isb_pkg::SUB_CLEAR, 0, 8'h01, 0);
      @(posedge REF_CLK) SUBMODE_PV <= 1'b1;
      cfg(1'b0, isb_pkg::SUB_MAX, 0, 8'h00, 32'h10);
      cfg(1'b0, isb_pkg::SUB_BYTES, 0, 8'h00, 32'h8);
      cfg(1'b1, isb_pkg::SUB_SIZE, 32'h11, 8'h01, 0);
      cfg(1'b1, isb_pkg::SUB_SIZE, 0, 8'h01, 0);
      cfg(1'b1, isb_pkg::SUB_ORG, 32'h2, 8'h01, 0);
      cfg(1'b1, isb_pkg::SUB_SIZE, 32'h4, 8'h00, 0);
   endtask

   // Three records queue up, SYNC starts the path, then a burst overruns.
   task automatic t_run;
      cfg(1'b1, isb_pkg::SUB_CLEAR, 0, 8'h00, 0);
      cfg(1'b1, isb_pkg::SUB_CLEAR, 32'h1, 8'h00, 0);
      send(6'h3, 1'b1);
      repeat (3) @(posedge REF_CLK);
      #1 chk(BUF_LEVEL, 32'h3);
      start(32'h64);
      wait_sp(32'h65);
      chk(INTERP_ACTIVE, 32'h1);
      cfg(1'b1, isb_pkg::SUB_ORG, 0, 8'hB9, 0);
      send(6'h4, 1'b0);
      @(posedge REF_CLK) #1 chk(EMCY_OVERFLOW, 32'h1);
      chk(BUF_LEVEL, 32'h4);
      wait_sp(32'h64);
   endtask

   task automatic t_underflow;
      int   i;
      logic ex;
      ex = 1'b0;
      for (i = 0; i < 400 && EMCY_UNDERFLOW !== 1'b1; i++) begin
         @(posedge REF_CLK) #1;
         if (SP_EXTRAP === 1'b1) ex = 1'b1;
      end
      chk(ex, 32'h1);
      chk(EMCY_UNDERFLOW, 32'h1);
      chk(HALT_REQ, 32'h1);
      chk(INTERP_ACTIVE, 32'h0);
      @(posedge REF_CLK) IP_ENABLE <= 1'b0;
   endtask

   // A closed buffer backs records up until the ingress FIFO refuses.
   task automatic t_fill;
      cfg(1'b1, isb_pkg::SUB_CLEAR, 0, 8'h00, 0);
      send(6'h20, 1'b0);
      chk(REC_READY, 32'h0);
      cfg(1'b1, isb_pkg::SUB_CLEAR, 0, 8'h00, 0);
      chk(REC_READY, 32'h1);
      chk(BUF_LEVEL, 32'h0);
   endtask

   // Ring layout: every record lands in the host slot, read from slot 0.
   task automatic t_ring;
      cfg(1'b1, isb_pkg::SUB_ORG, 32'h1, 8'h00, 0);
      cfg(1'b0, isb_pkg::SUB_ORG, 0, 8'h00, 32'h1);
      cfg(1'b1, isb_pkg::SUB_SLOT, 0, 8'h00, 0);
      cfg(1'b1, isb_pkg::SUB_CLEAR, 32'h1, 8'h00, 0);
      send(6'h3, 1'b0);
      start(32'h66);
   endtask

   task automatic finish_test;
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog allows far more than the roughly 300 cycles needed.
   initial begin
      #1000000;
      err_count++;
      finish_test;
   end

   // Reset, then the scenarios in order; 20-cycle period at unit 1.
   initial begin
      RESET_N = 1'b0;
      CFG_REQ = '0;
      {SUBMODE_PV, IP_ENABLE, SYNC, UF_MASK, OF_MASK} = 5'h00;
      {go, gap, cnt, err_count, checked} = '0;
      TIME_UNIT = 8'h01;
      TIME_INDEX = 8'hFA;
      TIMEOUT_PERIODS = 8'h02;
      repeat (8) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      t_regs;
      t_run;
      t_underflow;
      t_fill;
      t_ring;
      finish_test;
   end
endmodule
